// [include/scf_pkg.sv]
// package for the supply and can status flag block
package scf_pkg;
    // clock and filter timing
    localparam int CLK_MHZ = 125;
    localparam int FILT_TIME_US = 100;
    localparam int FILT_CYCLES = FILT_TIME_US * CLK_MHZ;
    localparam int SHORT_RST_TIME_MS = 100;
    localparam int SHORT_RST_CYCLES = SHORT_RST_TIME_MS * 1000 * CLK_MHZ;
    localparam int CNT_W = 24;
    // register byte offsets
    localparam logic [7:0] REG_SUPPLY_FLAGS_OFS = 8'h00;
    localparam logic [7:0] REG_CAN_STATUS_OFS = 8'h04;
    localparam logic [7:0] REG_CAN_CTRL_OFS = 8'h08;
    // supply flag field positions
    localparam int AUX_LOW_BIT = 0;
    localparam int AUX_OC_BIT = 1;
    localparam int CAN_THERM_BIT = 2;
    localparam int CAN_UV_BIT = 3;
    localparam int CAN_OC_BIT = 4;
    localparam int SENSE_LOW_BIT = 5;
    localparam int BATT_LOW_BIT = 6;
    localparam int CORE_OC_RUN_BIT = 7;
    localparam int CORE_OC_LP_BIT = 8;
    localparam int CORE_THERM_BIT = 9;
    localparam int SHORT_RST_BIT = 10;
    localparam int BATT_FAIL_BIT = 11;
    localparam int NUM_FLAGS = 12;
    // can status field positions
    localparam int CAN_DRV_BIT = 0;
    localparam int CAN_RCV_BIT = 1;
    localparam int CAN_WAKE_RCV_BIT = 2;
    localparam int CAN_WAKE_SRC_BIT = 3;
    // can control field positions and reset value
    localparam int CTRL_DRV_EN_BIT = 0;
    localparam int CTRL_RCV_EN_BIT = 1;
    localparam int CTRL_WAKE_EN_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h7;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : scf_pkg

// [verilog/scf_status_flags.sv]
// supply monitor and can status flags with an axi4-lite register slave
//
// How it works
// - aux low set after 100us filtered; clears when gone and read
// - aux overcurrent set after 100us filtered; clears when gone and read
// - can supply thermal set while hot; clears when cool and read
// - can supply undervoltage set after 100us; clears when gone and read
// - can supply overcurrent set after 100us; clears when gone and read
// - sense pin low set after 100us; clears when gone and read
// - battery supply low set after 100us; clears when gone and read
// - core overcurrent in run mode after 100us; clears when gone, read
// - core overcurrent in low power mode after 100us; clears gone, read
// - core thermal set when regulator off; clears on recovery and read
// - reset low pulse under 100ms sets flag; clears after end and read
// - battery fail set below threshold; clears when above and read
// - driver state live: 1 enabled, 0 by command or failure
// - receiver state live: 1 enabled, 0 when commanded off
// - wake receiver state live, commanded, enabled after power-on
// - status read leaves live can state bits unchanged
// - can wake source flag set on wake, cleared by read
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module scf_status_flags (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic aux_supply_low_i,
    input wire logic aux_supply_oc_i,
    input wire logic can_supply_hot_i,
    input wire logic can_supply_low_i,
    input wire logic can_supply_oc_i,
    input wire logic sense_pin_low_i,
    input wire logic battery_supply_pin_low_i,
    input wire logic core_oc_i,
    input wire logic low_power_mode_i,
    input wire logic core_thermal_off_i,
    input wire logic reset_pin_i,
    input wire logic battery_fail_threshold_i,
    input wire logic can_txd_dominant_fail_i,
    input wire logic can_wake_i,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic can_driver_enable_o,
    output logic can_receiver_enable_o,
    output logic can_wake_receiver_live_state_o
);

    localparam int NF = scf_pkg::NUM_FLAGS;
    localparam int NI = 14;
    // reset pin idles high, so no false short pulse follows reset
    localparam logic [NI-1:0] SYNC_IDLE = 14'h0400;
    localparam int CW = scf_pkg::CNT_W;
    localparam logic [CW-1:0] FILT_MAX = CW'(scf_pkg::FILT_CYCLES);
    localparam logic [CW-1:0] RST_MAX = CW'(scf_pkg::SHORT_RST_CYCLES);

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers
    logic [NI-1:0] raw_in;
    logic [NI-1:0] sync1_r;
    logic [NI-1:0] sync2_r;

    assign raw_in = {can_wake_i, can_txd_dominant_fail_i,
        battery_fail_threshold_i, reset_pin_i, core_thermal_off_i,
        low_power_mode_i, core_oc_i, battery_supply_pin_low_i,
        sense_pin_low_i, can_supply_oc_i, can_supply_low_i,
        can_supply_hot_i, aux_supply_oc_i, aux_supply_low_i};

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync1_r <= SYNC_IDLE;
            sync2_r <= SYNC_IDLE;
        end else begin
            sync1_r <= raw_in;
            sync2_r <= sync1_r;
        end
    end

    wire s_aux_low = sync2_r[0];
    wire s_aux_oc = sync2_r[1];
    wire s_can_hot = sync2_r[2];
    wire s_can_low = sync2_r[3];
    wire s_can_oc = sync2_r[4];
    wire s_sense_low = sync2_r[5];
    wire s_batt_low = sync2_r[6];
    wire s_core_oc = sync2_r[7];
    wire s_low_power = sync2_r[8];
    wire s_core_off = sync2_r[9];
    wire s_rst_pin = sync2_r[10];
    wire s_batt_fail = sync2_r[11];
    wire s_txd_fail = sync2_r[12];
    wire s_can_wake = sync2_r[13];

    ////////////////////////////////////////////////////////////////////////
    // 100us condition filters
    localparam int NFILT = 8;
    logic [NFILT-1:0] filt_cond;
    logic [NFILT-1:0] filt_hit;
    logic [CW-1:0] filt_cnt_r [NFILT];

    assign filt_cond = {s_core_oc & s_low_power, s_core_oc & ~s_low_power,
        s_batt_low, s_sense_low, s_can_oc, s_can_low, s_aux_oc, s_aux_low};

    function automatic logic [CW-1:0] filt_step(input logic cond,
        input logic [CW-1:0] cnt);
        if (!cond) begin
            filt_step = '0;
        end else if (cnt == FILT_MAX) begin
            filt_step = cnt;
        end else begin
            filt_step = cnt + CW'(1);
        end
    endfunction : filt_step

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < NFILT; i++) begin
                filt_cnt_r[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NFILT; i++) begin
                filt_cnt_r[i] <= filt_step(filt_cond[i], filt_cnt_r[i]);
            end
        end
    end

    always_comb begin
        for (int i = 0; i < NFILT; i++) begin
            filt_hit[i] = filt_cond[i] && (filt_cnt_r[i] == FILT_MAX);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // short reset pulse detector
    logic [CW-1:0] rst_cnt_r;
    logic rst_pin_d_r;
    logic rst_long_r;
    wire rst_rise = s_rst_pin & ~rst_pin_d_r;
    wire short_rst_evt = rst_rise & ~rst_long_r;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_cnt_r <= '0;
            rst_pin_d_r <= 1'b1;
            rst_long_r <= 1'b0;
        end else begin
            rst_pin_d_r <= s_rst_pin;
            if (s_rst_pin) begin
                rst_cnt_r <= '0;
                rst_long_r <= 1'b0;
            end else if (rst_cnt_r == RST_MAX) begin
                rst_long_r <= 1'b1;
            end else begin
                rst_cnt_r <= rst_cnt_r + CW'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // latched flags: set by event, cleared once condition gone and read
    logic [NF-1:0] flag_set;
    logic [NF-1:0] flag_active;
    logic [NF-1:0] flag_r;
    logic [NF-1:0] read_mask_r;
    logic flag_read;

    assign flag_set[scf_pkg::AUX_LOW_BIT] = filt_hit[0];
    assign flag_set[scf_pkg::AUX_OC_BIT] = filt_hit[1];
    assign flag_set[scf_pkg::CAN_THERM_BIT] = s_can_hot;
    assign flag_set[scf_pkg::CAN_UV_BIT] = filt_hit[2];
    assign flag_set[scf_pkg::CAN_OC_BIT] = filt_hit[3];
    assign flag_set[scf_pkg::SENSE_LOW_BIT] = filt_hit[4];
    assign flag_set[scf_pkg::BATT_LOW_BIT] = filt_hit[5];
    assign flag_set[scf_pkg::CORE_OC_RUN_BIT] = filt_hit[6];
    assign flag_set[scf_pkg::CORE_OC_LP_BIT] = filt_hit[7];
    assign flag_set[scf_pkg::CORE_THERM_BIT] = s_core_off;
    assign flag_set[scf_pkg::SHORT_RST_BIT] = short_rst_evt;
    assign flag_set[scf_pkg::BATT_FAIL_BIT] = s_batt_fail;

    // raw conditions that hold a flag against clearing
    assign flag_active = {s_batt_fail, ~s_rst_pin, s_core_off,
        filt_cond[7], filt_cond[6], s_batt_low, s_sense_low, s_can_oc,
        s_can_low, s_can_hot, s_aux_oc, s_aux_low};

    // a read arms the clear; set always wins over clear
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flag_r <= '0;
            read_mask_r <= '0;
        end else begin
            flag_r <= flag_set | (flag_r & ~(read_mask_r & ~flag_active));
            read_mask_r <= (flag_read ? flag_r : read_mask_r)
                & ~flag_set & flag_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // can live state and wake source
    logic [2:0] can_ctrl_r;
    logic wake_src_r;
    logic wake_read;

    assign can_driver_enable_o = can_ctrl_r[scf_pkg::CTRL_DRV_EN_BIT]
        & ~s_txd_fail;
    assign can_receiver_enable_o =
        can_ctrl_r[scf_pkg::CTRL_RCV_EN_BIT];
    assign can_wake_receiver_live_state_o =
        can_ctrl_r[scf_pkg::CTRL_WAKE_EN_BIT];

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wake_src_r <= 1'b0;
        end else if (s_can_wake) begin
            wake_src_r <= 1'b1;
        end else if (wake_read) begin
            wake_src_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite slave
    logic aw_held_r;
    logic w_held_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    assign s_axi_awready = ~aw_held_r & ~bvalid_r;
    assign s_axi_wready = ~w_held_r & ~bvalid_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire wr_go = (aw_held_r | aw_take) & (w_held_r | w_take);
    wire [7:0] wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
    wire [31:0] wr_data = w_held_r ? w_data_r : s_axi_wdata;
    wire [3:0] wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;
    wire wr_ctrl = wr_addr == scf_pkg::REG_CAN_CTRL_OFS;
    wire wr_ok = wr_ctrl | (wr_addr == scf_pkg::REG_SUPPLY_FLAGS_OFS)
        | (wr_addr == scf_pkg::REG_CAN_STATUS_OFS);

    wire rd_take = s_axi_arvalid & s_axi_arready;
    wire rd_flags = s_axi_araddr == scf_pkg::REG_SUPPLY_FLAGS_OFS;
    wire rd_can = s_axi_araddr == scf_pkg::REG_CAN_STATUS_OFS;
    wire rd_ctrl = s_axi_araddr == scf_pkg::REG_CAN_CTRL_OFS;
    wire [31:0] can_word = {28'h0, wake_src_r,
        can_wake_receiver_live_state_o, can_receiver_enable_o,
        can_driver_enable_o};
    wire [31:0] rd_word = rd_flags ? {{(32-NF){1'b0}}, flag_r}
        : rd_can ? can_word
        : rd_ctrl ? {29'h0, can_ctrl_r} : 32'h0;

    assign flag_read = rd_take & rd_flags;
    // status read clears only the wake source, never the live bits
    assign wake_read = rd_take & rd_can;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0;
            w_strb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= scf_pkg::RESP_OKAY;
            can_ctrl_r <= scf_pkg::CTRL_RESET;
        end else begin
            if (aw_take) begin
                aw_addr_r <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            aw_held_r <= (aw_held_r | aw_take) & ~wr_go;
            w_held_r <= (w_held_r | w_take) & ~wr_go;
            if (wr_go) begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_ok ? scf_pkg::RESP_OKAY : scf_pkg::RESP_SLVERR;
                if (wr_ctrl && wr_strb[0]) begin
                    can_ctrl_r <= wr_data[2:0];
                end
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0;
            rresp_r <= scf_pkg::RESP_OKAY;
        end else if (rd_take) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_word;
            rresp_r <= (rd_flags | rd_can | rd_ctrl) ? scf_pkg::RESP_OKAY
                : scf_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

endmodule : scf_status_flags

// [tb/scf_status_flags_asserts.sv]
// assertions on the status flag block ports
`timescale 1ns/1ps
module scf_status_flags_asserts (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic can_supply_hot_i,
    input wire logic core_thermal_off_i,
    input wire logic battery_fail_threshold_i,
    input wire logic can_txd_dominant_fail_i,
    input wire logic can_wake_i,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic can_driver_enable_o,
    input wire logic can_receiver_enable_o,
    input wire logic can_wake_receiver_live_state_o
);
default clocking @(posedge clk_i); endclocking
default disable iff (!reset_n_i);
sequence s_ctrl_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && s_axi_awaddr == 8'h08 && s_axi_wstrb[0];
endsequence
sequence s_rd(a);
    s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
endsequence
a_can_hot_flag: assert property (
    can_supply_hot_i [*8] ##0 s_rd(8'h00) |=> s_axi_rdata[2])
    else $error("can supply thermal flag missing");
a_core_hot_flag: assert property (
    core_thermal_off_i [*8] ##0 s_rd(8'h00) |=> s_axi_rdata[9])
    else $error("core thermal flag missing");
a_batt_fail_flag: assert property (
    battery_fail_threshold_i [*8] ##0 s_rd(8'h00) |=> s_axi_rdata[11])
    else $error("battery fail flag missing");
a_wake_src_flag: assert property (
    can_wake_i [*6] ##0 s_rd(8'h04) |=> s_axi_rdata[3])
    else $error("can wake source flag missing");
a_txd_fail_drv: assert property (
    can_txd_dominant_fail_i [*3] |-> !can_driver_enable_o)
    else $error("driver state high during transmit failure");
a_drv_cmd_off: assert property (
    s_ctrl_wr ##0 !s_axi_wdata[0] |-> ##2 !can_driver_enable_o)
    else $error("driver state not off after command");
a_rcv_cmd_on: assert property (
    s_ctrl_wr ##0 s_axi_wdata[1] |-> ##2 can_receiver_enable_o)
    else $error("receiver state not on after command");
a_wake_rcv_reset: assert property (
    $rose(reset_n_i) |-> can_wake_receiver_live_state_o)
    else $error("wake receiver not active after reset");
a_status_read_keep: assert property (
    s_rd(8'h04) ##0 (!s_axi_awvalid && !s_axi_wvalid) |=>
        $stable(can_receiver_enable_o)
        && $stable(can_wake_receiver_live_state_o))
    else $error("status read changed live can state");
endmodule : scf_status_flags_asserts
bind scf_status_flags scf_status_flags_asserts u_asserts (.clk_i, .reset_n_i,
    .can_supply_hot_i, .core_thermal_off_i, .battery_fail_threshold_i,
    .can_txd_dominant_fail_i, .can_wake_i, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .can_driver_enable_o, .can_receiver_enable_o,
    .can_wake_receiver_live_state_o);

// [tb/scf_host_model.sv]
// host side model mastering the axi4-lite register bus
`timescale 1ns/1ps
module scf_host_model (
    input wire logic clk_i,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
end
task automatic wr(input logic [7:0] a, input logic [31:0] d,
                  output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
        @(posedge clk_i);
        if (!aw_ok && s_axi_awready) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~a;
        end
        if (!w_ok && s_axi_wready) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~d;
        end
    end
    do @(posedge clk_i); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
endtask : wr
task automatic rd(input logic [7:0] a, output logic [31:0] d,
                  output logic [1:0] r);
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_i); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    do @(posedge clk_i); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
endtask : rd
endmodule : scf_host_model

// [tb/scf_status_flags_bench.sv]
// self-checking bench for the status flag block
`timescale 1ns/1ps
module scf_status_flags_bench;
logic clk_i = 1'b0;
logic reset_n_i = 1'b0;
logic [13:0] cond = 14'h0400;
logic [7:0] s_axi_awaddr, s_axi_araddr;
logic [31:0] s_axi_wdata, s_axi_rdata;
logic [3:0] s_axi_wstrb;
logic [1:0] s_axi_bresp, s_axi_rresp;
logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
logic s_axi_rvalid, s_axi_rready, drv, rcv, wake;
int fails = 0;
int checks = 0;
int cycles = 0;
initial forever #4 clk_i = ~clk_i;
scf_status_flags dut (.clk_i, .reset_n_i, .aux_supply_low_i(cond[0]),
    .aux_supply_oc_i(cond[1]), .can_supply_hot_i(cond[2]),
    .can_supply_low_i(cond[3]), .can_supply_oc_i(cond[4]),
    .sense_pin_low_i(cond[5]), .battery_supply_pin_low_i(cond[6]),
    .core_oc_i(cond[7]), .low_power_mode_i(cond[8]),
    .core_thermal_off_i(cond[9]), .reset_pin_i(cond[10]),
    .battery_fail_threshold_i(cond[11]), .can_txd_dominant_fail_i(cond[12]),
    .can_wake_i(cond[13]), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .can_driver_enable_o(drv), .can_receiver_enable_o(rcv),
    .can_wake_receiver_live_state_o(wake));
scf_host_model host (.clk_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
        fails++;
        $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
endtask : chk
task rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    host.rd(a, d, r);
    chk("read data", d, exp);
    chk("read resp", {30'h0, r}, {30'h0, scf_pkg::RESP_OKAY});
endtask : rdc
task print_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
endtask : print_verdict
always @(posedge clk_i) begin
    cycles++;
    if (cycles == 60000) begin
        fails++;
        print_verdict;
    end
end
////////////////////////////////////////////////////////////////////////////
initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    rdc(8'h00, 32'h0);
    rdc(8'h04, 32'h7);
    rdc(8'h08, 32'h7);
    chk("live pins", {29'h0, wake, rcv, drv}, 32'h7);
    host.rd(8'h0c, d, r);
    chk("unmapped data", d, 32'h0);
    chk("unmapped resp", {30'h0, r}, {30'h0, scf_pkg::RESP_SLVERR});
    host.wr(8'h00, 32'hffffffff, r);
    chk("ro write resp", {30'h0, r}, {30'h0, scf_pkg::RESP_OKAY});
    rdc(8'h00, 32'h0);
    // unfiltered faults plus a short reset pin pulse
    cond <= 14'h0a04;
    repeat (20) @(posedge clk_i);
    cond <= 14'h0e04;
    repeat (10) @(posedge clk_i);
    rdc(8'h00, 32'he04);
    repeat (10) @(posedge clk_i);
    rdc(8'h00, 32'ha04);
    cond <= 14'h0400;
    repeat (10) @(posedge clk_i);
    rdc(8'h00, 32'ha04);
    rdc(8'h00, 32'h0);
    // filtered faults, glitch restarts the count
    cond <= 14'h04fb;
    repeat (12000) @(posedge clk_i);
    rdc(8'h00, 32'h0);
    cond <= 14'h0400;
    repeat (2) @(posedge clk_i);
    cond <= 14'h04fb;
    repeat (12000) @(posedge clk_i);
    rdc(8'h00, 32'h0);
    repeat (600) @(posedge clk_i);
    rdc(8'h00, 32'hfb);
    cond <= 14'h05fb;
    repeat (12600) @(posedge clk_i);
    rdc(8'h00, 32'h1fb);
    cond <= 14'h0400;
    repeat (10) @(posedge clk_i);
    rdc(8'h00, 32'h17b);
    rdc(8'h00, 32'h0);
    // live can state and wake source
    host.wr(8'h08, 32'h0, r);
    chk("ctrl write resp", {30'h0, r}, {30'h0, scf_pkg::RESP_OKAY});
    rdc(8'h04, 32'h0);
    chk("live pins", {29'h0, wake, rcv, drv}, 32'h0);
    rdc(8'h04, 32'h0);
    host.wr(8'h08, 32'h3, r);
    rdc(8'h04, 32'h3);
    chk("live pins", {29'h0, wake, rcv, drv}, 32'h3);
    cond <= 14'h1400;
    repeat (5) @(posedge clk_i);
    rdc(8'h04, 32'h2);
    chk("live pins", {29'h0, wake, rcv, drv}, 32'h2);
    cond <= 14'h2400;
    repeat (8) @(posedge clk_i);
    rdc(8'h04, 32'hb);
    cond <= 14'h0400;
    repeat (5) @(posedge clk_i);
    rdc(8'h04, 32'hb);
    rdc(8'h04, 32'h3);
    host.wr(8'h08, 32'h7, r);
    rdc(8'h08, 32'h7);
    chk("live pins", {29'h0, wake, rcv, drv}, 32'h7);
    host.wr(8'h10, 32'h0, r);
    chk("unmapped wr resp", {30'h0, r}, {30'h0, scf_pkg::RESP_SLVERR});
    print_verdict;
end
endmodule : scf_status_flags_bench
